// >>> core/bws_regs.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module bws_regs
  import bws_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  // AXI4-Lite write address
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // AXI4-Lite read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Window decode view
  output logic             o_io_space,
  output logic             o_wide,
  output logic             o_prefetch,
  output logic [63:0]      o_base,
  output logic [63:0]      o_mask
);
  typedef enum logic [2:0] {
    BWS_W_IDLE = 3'b001,
    BWS_W_DATA = 3'b010,
    BWS_W_RESP = 3'b100
  } bws_wst_t;

  logic [31:0] setup_r, setup_nxt;
  logic [63:0] base_r, base_nxt;
  logic [11:0] awaddr_r;
  logic        aw_have_r, w_have_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;
  bws_wst_t    wst_r;
  bws_wst_t    wst_nxt;

  // Field decode
  wire        space_io = setup_r[BWS_SPACE_BIT];
  wire [1:0]  type_raw = setup_r[BWS_TYPE_LSB +: 2];
  wire [1:0]  type_eff = space_io ? 2'h0 : type_raw;
  wire        wide     = !space_io && (type_eff == BWS_TYPE_A64);
  wire [5:0]  size_f   = setup_r[BWS_SIZE_LSB +: 6];
  wire [63:0] mask;

  bws_mask u_mask (
    .i_size (size_f),
    .i_wide (wide),
    .o_mask (mask)
  );

  // Write path
  wire aw_take = i_awvalid && !aw_have_r && !bvalid_r;
  wire w_take  = i_wvalid && !w_have_r && !bvalid_r;
  wire aw_ok   = aw_have_r || aw_take;
  wire w_ok    = w_have_r || w_take;
  wire [11:0] wa  = aw_have_r ? awaddr_r : i_awaddr;
  wire [31:0] wd  = w_have_r ? wdata_r : i_wdata;
  wire [3:0]  ws  = w_have_r ? wstrb_r : i_wstrb;
  wire do_wr = aw_ok && w_ok && !bvalid_r;
  wire [31:0] bmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire hit_s0 = (wa == BWS_OFF_SETUP0);
  wire hit_b0 = (wa == BWS_OFF_BASE0);
  wire hit_b1 = (wa == BWS_OFF_BASE1);
  wire hit_s1 = (wa == BWS_OFF_SETUP1);
  wire wr_ok  = hit_s0 || hit_b0 || hit_b1 || hit_s1;
  wire [31:0] s_m = bmask & BWS_SETUP0_WMASK;
  wire [31:0] s_w = (setup_r & ~s_m) | (wd & s_m);
  wire [31:0] b0_w = (base_r[31:0] & ~bmask) | (wd & bmask);
  wire [31:0] b1_w = (base_r[63:32] & ~bmask) | (wd & bmask);

  // Setup 1 is not modelled beyond reading zero; base 1 is the upper half in wide mode
  assign setup_nxt = (do_wr && hit_s0) ? s_w : setup_r;

  // Mask of the setup about to be stored, so a shrinking window clears base bits on the same edge
  wire        space_io_nxt = setup_nxt[BWS_SPACE_BIT];
  wire [1:0]  type_raw_nxt = setup_nxt[BWS_TYPE_LSB +: 2];
  wire        wide_nxt     = !space_io_nxt && (type_raw_nxt == BWS_TYPE_A64);
  wire [5:0]  size_nxt     = setup_nxt[BWS_SIZE_LSB +: 6];
  wire [63:0] mask_nxt;

  bws_mask u_mask_nxt (
    .i_size (size_nxt),
    .i_wide (wide_nxt),
    .o_mask (mask_nxt)
  );

  always_comb begin
    base_nxt = base_r;
    if (do_wr && hit_b0) begin
      base_nxt[31:0] = b0_w;
    end
    if (do_wr && hit_b1 && wide) begin
      base_nxt[63:32] = b1_w;
    end
    base_nxt = base_nxt & mask_nxt;
  end

  // Write channel phase, kept in step with the held halves and the response
  always_comb begin
    wst_nxt = wst_r;
    case (wst_r)
      BWS_W_IDLE: begin
        if (do_wr) begin
          wst_nxt = BWS_W_RESP;
        end else if (aw_ok || w_ok) begin
          wst_nxt = BWS_W_DATA;
        end
      end
      BWS_W_DATA: begin
        if (do_wr) begin
          wst_nxt = BWS_W_RESP;
        end
      end
      BWS_W_RESP: begin
        if (bvalid_r && i_bready) begin
          wst_nxt = BWS_W_IDLE;
        end
      end
      default: begin
        wst_nxt = BWS_W_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      setup_r <= BWS_SETUP_RST;
      base_r  <= 64'h0;
      wst_r   <= BWS_W_IDLE;
    end else begin
      setup_r <= setup_nxt;
      base_r  <= base_nxt;
      wst_r   <= wst_nxt;
    end
  end

  // Address half held until its data partner arrives
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_have_r <= 1'b0;
      awaddr_r  <= 12'h000;
    end else if (do_wr) begin
      aw_have_r <= 1'b0;
    end else if (aw_take) begin
      aw_have_r <= 1'b1;
      awaddr_r  <= i_awaddr;
    end
  end

  // Data half held until its address partner arrives
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w_have_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (do_wr) begin
      w_have_r <= 1'b0;
    end else if (w_take) begin
      w_have_r <= 1'b1;
      wdata_r  <= i_wdata;
      wstrb_r  <= i_wstrb;
    end
  end

  // Write response stands until the host takes it
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= 2'h0;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? BWS_RESP_OKAY : BWS_RESP_SLVERR;
    end else if (bvalid_r && i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read path
  wire ar_take = i_arvalid && !rvalid_r;
  wire [31:0] s0_view = {22'h0, size_f, setup_r[BWS_PREFETCH_BIT], type_eff, space_io};
  wire [31:0] b0_view = {base_r[31:4], setup_r[BWS_PREFETCH_BIT], type_eff, space_io};
  wire [31:0] b1_view = wide ? base_r[63:32] : 32'h0000_0000;
  wire rd_s0 = (i_araddr == BWS_OFF_SETUP0);
  wire rd_b0 = (i_araddr == BWS_OFF_BASE0);
  wire rd_b1 = (i_araddr == BWS_OFF_BASE1);
  wire rd_s1 = (i_araddr == BWS_OFF_SETUP1);
  wire rd_ok = rd_s0 || rd_b0 || rd_b1 || rd_s1;
  wire [31:0] rd_sel = rd_s0 ? s0_view :
                       rd_b0 ? b0_view :
                       rd_b1 ? b1_view : 32'h0000_0000;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'h0;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_sel;
      rresp_r  <= rd_ok ? BWS_RESP_OKAY : BWS_RESP_SLVERR;
    end else if (rvalid_r && i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign o_awready  = !aw_have_r && !bvalid_r;
  assign o_wready   = !w_have_r && !bvalid_r;
  assign o_bvalid   = bvalid_r;
  assign o_bresp    = bresp_r;
  assign o_arready  = !rvalid_r;
  assign o_rvalid   = rvalid_r;
  assign o_rdata    = rdata_r;
  assign o_rresp    = rresp_r;
  assign o_io_space = space_io;
  assign o_wide     = wide;
  assign o_prefetch = setup_r[BWS_PREFETCH_BIT];
  assign o_base     = base_r;
  assign o_mask     = mask;

  // Field and window checks
  io_type_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    space_io |-> s0_view[2:1] == 2'h0 && b0_view[2:1] == 2'h0 && !wide) else $error("type not zero in I/O space");
  base_masked_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (base_r & ~mask) == 64'h0) else $error("base bit outside mask");
  small_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (size_f != 6'h00 && size_f < BWS_SIZE_MIN) |-> mask == 64'h0) else $error("small size not disabled");
  full_space_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (size_f == 6'h00) |-> mask == 64'hFFFF_FFFF_FFFF_FFF0) else $error("size zero not full");
  narrow_cap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (!wide && size_f > BWS_SIZE_32) |-> mask[31:0] == 32'h0) else $error("narrow size not capped");
  bar_view_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    b0_view[2:1] == (space_io ? BWS_TYPE_A32 : setup_r[BWS_TYPE_LSB +: 2])) else $error("type view wrong");
  setup1_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (ar_take && i_araddr == BWS_OFF_SETUP1) |=> rdata_r == 32'h0) else $error("setup1 not zero");
  prefetch_view_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    b0_view[3] == setup_r[BWS_PREFETCH_BIT] && o_prefetch == setup_r[BWS_PREFETCH_BIT])
    else $error("prefetch view wrong");
  size_pow2_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (size_f >= BWS_SIZE_MIN && (wide || size_f <= BWS_SIZE_32)) |-> mask[size_f] && !mask[size_f - 6'h01])
    else $error("window size not a power of two");
  base_low_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    base_r[BWS_BASE_LSB-1:0] == '0) else $error("base bits below four not zero");
  base_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (do_wr && hit_b0 && ws == 4'hF) |=> base_r[31:0] == ($past(wd) & $past(mask[31:0])))
    else $error("base write not masked");
  full_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (do_wr && hit_b1 && wide && size_f == 6'h00 && ws == 4'hF) |=> base_r[63:32] == $past(wd))
    else $error("upper base not writable");
  b1_narrow_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (ar_take && rd_b1 && !wide) |=> rdata_r == 32'h0) else $error("base1 not zero when narrow");
  b1_wide_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (ar_take && rd_b1 && wide) |=> rdata_r == $past(base_r[63:32])) else $error("base1 not upper half");
  setup_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (do_wr && hit_s0 && ws == 4'hF) |=> setup_r == ($past(wd) & BWS_SETUP0_WMASK)) else $error("setup not stored");
  unmapped_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (do_wr && !wr_ok) |=> $stable(setup_r) && $stable(base_r)) else $error("unmapped write had effect");
  unmapped_rd_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (ar_take && !rd_ok) |=> rresp_r == BWS_RESP_SLVERR && rdata_r == 32'h0) else $error("unmapped read wrong");

  // Handshake checks
  write_resp_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    do_wr |=> bvalid_r) else $error("write not answered");
  read_answer_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ar_take |=> rvalid_r) else $error("read not answered");
  bresp_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (bvalid_r && !i_bready) |=> bvalid_r && $stable(bresp_r)) else $error("write response dropped");
  rdata_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (rvalid_r && !i_rready) |=> rvalid_r && $stable(rdata_r) && $stable(rresp_r)) else $error("read data dropped");
  no_accept_busy_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    bvalid_r |-> !o_awready && !o_wready) else $error("write taken while answer pending");
  read_busy_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    rvalid_r |-> !o_arready) else $error("read taken while answer pending");
  aw_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (aw_take && !do_wr) |=> aw_have_r && awaddr_r == $past(i_awaddr)) else $error("address half lost");
  wr_phase_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (wst_r == BWS_W_RESP) == bvalid_r) else $error("write phase out of step");
  half_held_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (wst_r == BWS_W_DATA) == (aw_have_r || w_have_r)) else $error("held half out of step");

  // Coverage
  wr_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) do_wr && hit_s0);
  wide_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) wide);
  io_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) space_io);
  base1_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) do_wr && hit_b1 && wide);
  small_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) size_f != 6'h00 && size_f < BWS_SIZE_MIN);
endmodule : bws_regs

// >>> core/bws_pkg.sv
package bws_pkg;
  localparam logic [11:0] BWS_OFF_SETUP0 = 12'h07C;
  localparam logic [11:0] BWS_OFF_BASE0  = 12'h010;
  localparam logic [11:0] BWS_OFF_BASE1  = 12'h014;
  localparam logic [11:0] BWS_OFF_SETUP1 = 12'h084;
  localparam int BWS_SPACE_BIT  = 0;
  localparam int BWS_TYPE_LSB   = 1;
  localparam int BWS_PREFETCH_BIT = 3;
  localparam int BWS_SIZE_LSB   = 4;
  localparam int BWS_BASE_LSB   = 4;
  localparam logic [1:0] BWS_TYPE_A32 = 2'h0;
  localparam logic [1:0] BWS_TYPE_A64 = 2'h2;
  localparam logic [5:0] BWS_SIZE_MIN = 6'h04;
  localparam logic [5:0] BWS_SIZE_32  = 6'h20;
  localparam logic [31:0] BWS_SETUP_RST = 32'h0000_0000;
  localparam logic [31:0] BWS_SETUP0_WMASK = 32'h0000_03FF;
  localparam logic [1:0] BWS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BWS_RESP_SLVERR = 2'h2;
endpackage : bws_pkg

// >>> core/bws_mask.sv
`timescale 1ns/1ps
module bws_mask
  import bws_pkg::*;
(
  // Setup
  input  wire logic [5:0]  i_size,
  input  wire logic        i_wide,
  // Writable mask of the 64-bit base, address bits 63:0
  output logic      [63:0] o_mask
);
  logic [6:0] eff_size;
  assign eff_size = (!i_wide && i_size > BWS_SIZE_32) ? {1'b0, BWS_SIZE_32} : {1'b0, i_size};
  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_bit
      if (g < BWS_BASE_LSB) begin : g_low
        assign o_mask[g] = 1'b0;
      end else begin : g_hi
        assign o_mask[g] = (eff_size == 7'h00) ? 1'b1 :
                           (eff_size < {1'b0, BWS_SIZE_MIN}) ? 1'b0 :
                           (7'(g) >= eff_size);
      end
    end
  endgenerate
endmodule : bws_mask

// >>> verif/bws_host.sv
`timescale 1ns/1ps
module bws_host (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  // Write side
  output logic      [11:0] o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic      [31:0] o_wdata,
  output logic      [3:0]  o_wstrb,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  // Read side
  output logic      [11:0] o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready} = '0;
  end
  // Window sizes handed in are the caller's duty; nothing below checks them
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    {o_awvalid, o_awaddr, o_wvalid, o_wdata, o_wstrb, o_bready} <= {1'b1, a, 1'b1, d, 4'hF, 1'b1};
    forever begin
      @(posedge i_sys_clk);
      if (o_awvalid && i_awready) {o_awvalid, o_awaddr} <= {1'b0, ~a};
      if (o_wvalid && i_wready) {o_wvalid, o_wdata} <= {1'b0, ~d};
      if (i_bvalid && o_bready) begin
        r = i_bresp;
        o_bready <= 1'b0;
        break;
      end
    end
    // One edge passes so a following call never reassigns a strobe in this step
    @(posedge i_sys_clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    {o_arvalid, o_araddr, o_rready} <= {1'b1, a, 1'b1};
    forever begin
      @(posedge i_sys_clk);
      if (o_arvalid && i_arready) {o_arvalid, o_araddr} <= {1'b0, ~a};
      if (i_rvalid && o_rready) begin
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
        break;
      end
    end
    @(posedge i_sys_clk);
  endtask : rd
endmodule : bws_host

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench
  import bws_pkg::*;
;
  logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, io_space, wide, prefetch;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [63:0] base, mask;
  int          num_errors = 0;
  int          num_checks = 0;
  int          ws[6] = '{0, 3, 4, 12, 32, 40};
  int          ns[3] = '{0, 20, 40};
  bws_regs bws_regs_inst (.i_sys_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_io_space(io_space), .o_wide(wide), .o_prefetch(prefetch), .o_base(base), .o_mask(mask));
  bws_host bws_host_inst (.i_sys_clk(clk), .i_rstn(rstn), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
    .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
    .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic rdc(string n, logic [11:0] a, logic [31:0] e, logic [1:0] er);
    logic [31:0] d;
    bws_host_inst.rd(a, d, r);
    chk(n, d, e);
    chk(n, r, er);
  endtask : rdc
  function automatic logic [63:0] xm(int s);
    return (s == 0) ? 64'hFFFF_FFFF_FFFF_FFF0 : (s < 4) ? 64'h0 : ~((64'h1 << s) - 64'h1);
  endfunction : xm
  // Optional reset pulse in mid-run, then reset state
  task automatic t_reset(bit pulse);
    if (pulse) begin
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
    end
    rdc("setup0", BWS_OFF_SETUP0, 32'h0, BWS_RESP_OKAY);
    chk("io", io_space, 0);
  endtask : t_reset
  task automatic t_fields();
    for (int sp = 0; sp < 2; sp++) begin
      for (int ty = 0; ty < 4; ty++) begin
        bws_host_inst.wr(BWS_OFF_SETUP0, {22'h0, 6'h08, ty[0], ty[1:0], sp[0]}, r);
        rdc("setup0", BWS_OFF_SETUP0, {22'h0, 6'h08, ty[0], sp ? 2'h0 : ty[1:0], sp[0]}, BWS_RESP_OKAY);
        rdc("base0", BWS_OFF_BASE0, {28'h0, ty[0], sp ? 2'h0 : ty[1:0], sp[0]}, BWS_RESP_OKAY);
        chk("wide", wide, sp == 0 && ty == 2);
        chk("io", io_space, sp);
        chk("prefetch", prefetch, ty[0]);
      end
    end
  endtask : t_fields
  task automatic t_size(int s, logic [1:0] ty, bit sp);
    logic [63:0] m;
    m = xm((ty == 2'h2 || s <= 32) ? s : 32);
    bws_host_inst.wr(BWS_OFF_SETUP0, {22'h0, s[5:0], 1'b0, ty, sp}, r);
    bws_host_inst.wr(BWS_OFF_BASE0, 32'hFFFF_FFFF, r);
    bws_host_inst.wr(BWS_OFF_BASE1, 32'hFFFF_FFFF, r);
    rdc("base0", BWS_OFF_BASE0, {m[31:4], 1'b0, ty, sp}, BWS_RESP_OKAY);
    rdc("base1", BWS_OFF_BASE1, (ty == 2'h2) ? m[63:32] : 32'h0, BWS_RESP_OKAY);
    rdc("setup1", BWS_OFF_SETUP1, 32'h0, BWS_RESP_OKAY);
    chk("base", base[31:0], m[31:0]);
    chk("mask", mask, m);
    if (ty == 2'h2) chk("base_hi", base[63:32], m[63:32]);
  endtask : t_size
  task automatic t_unmapped();
    bws_host_inst.wr(12'h100, 32'hFFFF_FFFF, r);
    chk("wresp", r, BWS_RESP_SLVERR);
    rdc("unmapped", 12'h100, 32'h0, BWS_RESP_SLVERR);
    rdc("setup0_kept", BWS_OFF_SETUP0, {22'h0, 6'h04, 1'b0, 2'h0, 1'b1}, BWS_RESP_OKAY);
  endtask : t_unmapped
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
  initial begin
    rstn = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset(1'b0);
    t_fields();
    foreach (ws[i]) t_size(ws[i], 2'h2, 1'b0);
    foreach (ns[i]) t_size(ns[i], 2'h0, 1'b0);
    t_size(4, 2'h0, 1'b1);
    t_unmapped();
    t_reset(1'b1);
    test_done();
  end
endmodule : testbench
